/* scp_consts.svh */
`ifndef SCP_CONSTS_SVH
`define SCP_CONSTS_SVH

// register indices; byte address is four times the index
`define SCP_IDX_INT_CTL 16'hFE0A
`define SCP_IDX_EXT_CTL 16'hFE0B
`define SCP_IDX_AUX_DIR 16'hFE0C
`define SCP_IDX_MODE 16'hFE0E

// reset values
`define SCP_RST_INT_CTL 8'h00
`define SCP_RST_EXT_CTL 8'h00
`define SCP_RST_AUX_DIR 8'h00
`define SCP_RST_MODE 8'h00

// internal card pin control fields
`define SCP_INT_C8 3
`define SCP_INT_C4 2
`define SCP_INT_CLK_LVL 1
`define SCP_INT_CLK_STOP 0

// external card pin control fields
`define SCP_EXT_IO 5
`define SCP_EXT_IO_DIR 4
`define SCP_EXT_CLK_LVL 1
`define SCP_EXT_CLK_STOP 0

// aux contact direction fields, 1 = input
`define SCP_DIR_C8 3
`define SCP_DIR_C4 2

// mode fields
`define SCP_MODE_BYPASS 0
`define SCP_MODE_INT_SYNC 1
`define SCP_MODE_EXT_SYNC 2

// bit-period half count in ref_clk cycles
`define SCP_CLK_HALF 14

// axi responses
`define SCP_RESP_OKAY 2'h0
`define SCP_RESP_DECERR 2'h3

`endif

/* scp_pkg.sv */
package scp_pkg;
  typedef logic [15:0] scp_idx_t;
  typedef logic [7:0] scp_byte_t;
  typedef logic [1:0] scp_resp_t;

  typedef struct packed {
    logic awTaken;
    scp_idx_t awIdx;
    logic wTaken;
    scp_byte_t wData;
    logic wLane0;
    logic bValid;
    scp_resp_t bResp;
    logic rValid;
    logic [31:0] rData;
    scp_resp_t rResp;
    scp_byte_t intCtl;
    scp_byte_t extCtl;
    scp_byte_t auxDir;
    scp_byte_t mode;
    logic extSample;
    logic extIoOut;
    logic extIoOe;
    logic c4Out;
    logic c4Oe;
    logic c8Out;
    logic c8Oe;
  } scp_regs_s;

  typedef struct packed {
    logic [15:0] cnt;
    logic phase;
    logic clkOut;
    logic rise;
  } scp_clkgen_s;
endpackage

/* scp_sync.sv */
`timescale 1ns/10ps
module scp_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // async in, synced out
  input wire logic [W-1:0] asyncIn,
  output logic [W-1:0] syncOut
);
  import scp_pkg::*;

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } scp_sync_s;

  scp_sync_s st_reg;
  scp_sync_s st_next;

  if (W < 1) begin : g_bad_w
    $error("scp_sync: W must be at least 1");
  end

  // first stage feeds only the second stage
  always_comb begin
    st_next = st_reg;
    st_next.s1 = asyncIn;
    st_next.s2 = st_reg.s1;
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign syncOut = st_reg.s2;
endmodule

/* scp_clkgen.sv */
`timescale 1ns/10ps
`include "scp_consts.svh"
module scp_clkgen #(
  parameter int CLK_HALF = `SCP_CLK_HALF
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // control
  input wire logic bypass,
  input wire logic clkStop,
  input wire logic idleLevel,
  // card clock
  output logic cardClk,
  output logic cardClkRise
);
  import scp_pkg::*;

  localparam logic [15:0] HALF_LAST = 16'(CLK_HALF - 1);

  if (CLK_HALF < 1 || CLK_HALF > 65536) begin : g_bad_half
    $error("scp_clkgen: CLK_HALF out of range");
  end

  scp_clkgen_s st_reg;
  scp_clkgen_s st_next;

  always_comb begin
    st_next = st_reg;
    // bit-period counter keeps running so a restart is phase-continuous
    if (st_reg.cnt == HALF_LAST) begin
      st_next.cnt = 16'h0000;
      st_next.phase = ~st_reg.phase;
    end else begin
      st_next.cnt = st_reg.cnt + 16'h0001;
    end
    if (bypass) begin
      st_next.clkOut = idleLevel;
    end else if (clkStop) begin
      st_next.clkOut = idleLevel;
    end else begin
      st_next.clkOut = st_next.phase;
    end
    st_next.rise = st_next.clkOut & ~st_reg.clkOut;
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign cardClk = st_reg.clkOut;
  assign cardClkRise = st_reg.rise;
endmodule

/* scp_pin_ctl.sv */
// Contract
// - output-configured aux contact drives its last written control bit
// - output aux contact reads back the stored register value
// - input aux contact reads back the pin level
// - writes to an input aux contact are stored but not driven
// - stopped internal card clock sits at the idle level bit
// - bypass drives internal card clock straight from the idle level bit
// - external io input direction reads back the pin level
// - external io output direction drives the written data bit
// - external io data and direction act only in bypass or sync
// - sync mode samples io on each external clock rising edge
// - external io direction bit: 1 input, 0 output
// - stopped external card clock sits at its idle level bit
// - bypass drives external card clock from its idle level bit
// - external stop bit: 0 enabled, 1 disabled at idle level
// - external stop bit does nothing in bypass
// - external control register at index FE0B, resets to zero
// - internal sync routes aux contacts to bits, clock from counter
// - external sync routes io to bits, clock from counter
// - separate direction bits for C8 and C4: 1 input, 0 output
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "scp_consts.svh"
module scp_pin_ctl #(
  parameter int ADDR_W = 18,
  parameter int CLK_HALF = `SCP_CLK_HALF
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // axi4-lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  // axi4-lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // axi4-lite write response
  output logic bvalid,
  input wire logic bready,
  output scp_pkg::scp_resp_t bresp,
  // axi4-lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  // axi4-lite read data
  input wire logic rvalid_unused_n,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output scp_pkg::scp_resp_t rresp,
  // internal card aux contacts C4 and C8
  input wire logic c4In,
  output logic c4Out,
  output logic c4Oe,
  input wire logic c8In,
  output logic c8Out,
  output logic c8Oe,
  // internal card clock
  output logic intCardClk,
  // external card io and clock
  input wire logic extIoIn,
  output logic extIoOut,
  output logic extIoOe,
  output logic extCardClk
);
  import scp_pkg::*;

  if (ADDR_W < 18 || ADDR_W > 32) begin : g_bad_addr
    $error("scp_pin_ctl: ADDR_W must be 18 to 32");
  end

  scp_regs_s st_reg;
  scp_regs_s st_next;
  // a literal cannot be bit-selected, so the reset direction gets a name
  localparam scp_byte_t AUX_DIR_RST = `SCP_RST_AUX_DIR;

  logic [2:0] pinSync;
  logic c4Pin;
  logic c8Pin;
  logic extIoPin;
  logic extClkRise;

  function automatic logic isMapped(input scp_idx_t idx);
    isMapped = (idx == `SCP_IDX_INT_CTL) || (idx == `SCP_IDX_EXT_CTL) ||
               (idx == `SCP_IDX_AUX_DIR) || (idx == `SCP_IDX_MODE);
  endfunction

  // pins pass two flops; the read is thus two cycles behind the pin
  scp_sync #(
    .W(3)
  ) u_sync (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .asyncIn({extIoIn, c8In, c4In}),
    .syncOut(pinSync)
  );
  assign c4Pin = pinSync[0];
  assign c8Pin = pinSync[1];
  assign extIoPin = pinSync[2];

  scp_clkgen #(
    .CLK_HALF(CLK_HALF)
  ) u_int_clk (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .bypass(st_reg.mode[`SCP_MODE_BYPASS]),
    .clkStop(st_reg.intCtl[`SCP_INT_CLK_STOP]),
    .idleLevel(st_reg.intCtl[`SCP_INT_CLK_LVL]),
    .cardClk(intCardClk),
    .cardClkRise()
  );

  scp_clkgen #(
    .CLK_HALF(CLK_HALF)
  ) u_ext_clk (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .bypass(st_reg.mode[`SCP_MODE_BYPASS]),
    .clkStop(st_reg.extCtl[`SCP_EXT_CLK_STOP]),
    .idleLevel(st_reg.extCtl[`SCP_EXT_CLK_LVL]),
    .cardClk(extCardClk),
    .cardClkRise(extClkRise)
  );

  logic awFire;
  logic wFire;
  logic arFire;
  logic doWrite;
  logic extActive;
  scp_idx_t wrIdx;
  scp_idx_t rdIdx;
  scp_byte_t wrByte;
  logic wrLane0;
  scp_byte_t rdByte;

  // one write outstanding; a new one waits until the response is taken
  assign awready = !st_reg.awTaken && !st_reg.bValid;
  assign wready = !st_reg.wTaken && !st_reg.bValid;
  assign arready = !st_reg.rValid;
  assign awFire = awvalid && awready;
  assign wFire = wvalid && wready;
  assign arFire = arvalid && arready;
  assign wrIdx = awFire ? awaddr[17:2] : st_reg.awIdx;
  assign wrByte = wFire ? wdata[7:0] : st_reg.wData;
  assign wrLane0 = wFire ? wstrb[0] : st_reg.wLane0;
  assign doWrite = (awFire || st_reg.awTaken) && (wFire || st_reg.wTaken);
  assign rdIdx = araddr[17:2];
  assign extActive = st_reg.mode[`SCP_MODE_BYPASS] || st_reg.mode[`SCP_MODE_EXT_SYNC];

  // read mux; unused high bits of each register read as zero
  always_comb begin
    rdByte = 8'h00;
    unique case (rdIdx)
      `SCP_IDX_INT_CTL: begin
        rdByte[`SCP_INT_C8] = st_reg.auxDir[`SCP_DIR_C8] ? c8Pin : st_reg.intCtl[`SCP_INT_C8];
        rdByte[`SCP_INT_C4] = st_reg.auxDir[`SCP_DIR_C4] ? c4Pin : st_reg.intCtl[`SCP_INT_C4];
        rdByte[`SCP_INT_CLK_LVL] = st_reg.intCtl[`SCP_INT_CLK_LVL];
        rdByte[`SCP_INT_CLK_STOP] = st_reg.intCtl[`SCP_INT_CLK_STOP];
      end
      `SCP_IDX_EXT_CTL: begin
        rdByte = st_reg.extCtl;
        if (st_reg.mode[`SCP_MODE_EXT_SYNC]) begin
          rdByte[`SCP_EXT_IO] = st_reg.extSample;
        end else if (st_reg.mode[`SCP_MODE_BYPASS] && st_reg.extCtl[`SCP_EXT_IO_DIR]) begin
          rdByte[`SCP_EXT_IO] = extIoPin;
        end
      end
      `SCP_IDX_AUX_DIR: rdByte = st_reg.auxDir;
      `SCP_IDX_MODE: rdByte = st_reg.mode;
      default: rdByte = 8'h00;
    endcase
  end

  always_comb begin
    st_next = st_reg;
    if (awFire) begin
      st_next.awTaken = 1'b1;
      st_next.awIdx = awaddr[17:2];
    end
    if (wFire) begin
      st_next.wTaken = 1'b1;
      st_next.wData = wdata[7:0];
      st_next.wLane0 = wstrb[0];
    end
    if (st_reg.bValid && bready) begin
      st_next.bValid = 1'b0;
    end
    if (doWrite) begin
      st_next.awTaken = 1'b0;
      st_next.wTaken = 1'b0;
      st_next.bValid = 1'b1;
      st_next.bResp = isMapped(wrIdx) ? `SCP_RESP_OKAY : `SCP_RESP_DECERR;
      if (wrLane0) begin
        unique case (wrIdx)
          // input aux contacts still store the written value
          `SCP_IDX_INT_CTL: st_next.intCtl = wrByte & 8'h0F;
          `SCP_IDX_EXT_CTL: st_next.extCtl = wrByte & 8'h33;
          `SCP_IDX_AUX_DIR: st_next.auxDir = wrByte & 8'h0C;
          `SCP_IDX_MODE: st_next.mode = wrByte & 8'h07;
          default: st_next.mode = st_reg.mode;
        endcase
      end
    end
    if (st_reg.rValid && rready) begin
      st_next.rValid = 1'b0;
    end
    if (arFire) begin
      st_next.rValid = 1'b1;
      st_next.rData = {24'h000000, rdByte};
      st_next.rResp = isMapped(rdIdx) ? `SCP_RESP_OKAY : `SCP_RESP_DECERR;
    end
    // sampled pin takes the latest rising edge of the external clock
    if (st_reg.mode[`SCP_MODE_EXT_SYNC] && extClkRise) begin
      st_next.extSample = extIoPin;
    end
    // pin drivers follow the next register values so they align with them
    st_next.c8Out = st_next.intCtl[`SCP_INT_C8];
    st_next.c8Oe = !st_next.auxDir[`SCP_DIR_C8];
    st_next.c4Out = st_next.intCtl[`SCP_INT_C4];
    st_next.c4Oe = !st_next.auxDir[`SCP_DIR_C4];
    st_next.extIoOut = st_next.extCtl[`SCP_EXT_IO];
    st_next.extIoOe = (st_next.mode[`SCP_MODE_BYPASS] || st_next.mode[`SCP_MODE_EXT_SYNC]) &&
                      !st_next.extCtl[`SCP_EXT_IO_DIR];
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      st_reg <= '0;
      st_reg.intCtl <= `SCP_RST_INT_CTL;
      st_reg.extCtl <= `SCP_RST_EXT_CTL;
      st_reg.auxDir <= `SCP_RST_AUX_DIR;
      st_reg.mode <= `SCP_RST_MODE;
      st_reg.c4Oe <= !AUX_DIR_RST[`SCP_DIR_C4];
      st_reg.c8Oe <= !AUX_DIR_RST[`SCP_DIR_C8];
    end else begin
      st_reg <= st_next;
    end
  end

  assign bvalid = st_reg.bValid;
  assign bresp = st_reg.bResp;
  assign rvalid = st_reg.rValid;
  assign rdata = st_reg.rData;
  assign rresp = st_reg.rResp;
  assign c4Out = st_reg.c4Out;
  assign c4Oe = st_reg.c4Oe;
  assign c8Out = st_reg.c8Out;
  assign c8Oe = st_reg.c8Oe;
  assign extIoOut = st_reg.extIoOut;
  assign extIoOe = st_reg.extIoOe;

  // helper: cycles the external clock has held while it should run
  // a restart can land just after a phase flip, so one half plus one is allowed
  localparam int HOLD_MAX = CLK_HALF + 1;
  logic [16:0] extHoldCnt;
  logic extClkPrev;
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      extHoldCnt <= 17'h00000;
      extClkPrev <= 1'b0;
    end else begin
      extClkPrev <= extCardClk;
      if (st_reg.mode[`SCP_MODE_BYPASS] || st_reg.extCtl[`SCP_EXT_CLK_STOP] || extCardClk != extClkPrev) begin
        extHoldCnt <= 17'h00000;
      end else begin
        extHoldCnt <= extHoldCnt + 17'h00001;
      end
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  chk_c8_drive: assert property (c8Oe |-> c8Out == st_reg.intCtl[`SCP_INT_C8] && !st_reg.auxDir[`SCP_DIR_C8])
    else $error("c8 driven with wrong value");
  chk_c4_input_float: assert property (st_reg.auxDir[`SCP_DIR_C4] |-> !c4Oe)
    else $error("c4 driven while input");
  chk_int_clk_bypass: assert property ($past(st_reg.mode[`SCP_MODE_BYPASS]) |->
    intCardClk == $past(st_reg.intCtl[`SCP_INT_CLK_LVL]))
    else $error("internal clock not following level in bypass");
  chk_int_clk_stop: assert property ($past(st_reg.intCtl[`SCP_INT_CLK_STOP]) |->
    intCardClk == $past(st_reg.intCtl[`SCP_INT_CLK_LVL]))
    else $error("internal clock not held while stopped");
  chk_ext_clk_bypass: assert property ($past(st_reg.mode[`SCP_MODE_BYPASS]) |->
    extCardClk == $past(st_reg.extCtl[`SCP_EXT_CLK_LVL]))
    else $error("external clock not following level in bypass");
  chk_ext_clk_stop: assert property ($past(st_reg.extCtl[`SCP_EXT_CLK_STOP]) |->
    extCardClk == $past(st_reg.extCtl[`SCP_EXT_CLK_LVL]))
    else $error("external clock not held while stopped");
  chk_ext_clk_runs: assert property (extHoldCnt <= 17'(HOLD_MAX))
    else $error("external clock stuck while enabled");
  chk_ext_io_idle: assert property (!extActive |-> !extIoOe)
    else $error("external io driven outside bypass and sync");
  chk_ext_io_drive: assert property (extIoOe |->
    extIoOut == st_reg.extCtl[`SCP_EXT_IO] && !st_reg.extCtl[`SCP_EXT_IO_DIR])
    else $error("external io driven with wrong value");
  chk_ext_sync_sample: assert property (st_reg.mode[`SCP_MODE_EXT_SYNC] && extClkRise |=>
    st_reg.extSample == $past(extIoPin))
    else $error("external io edge sample missed");
  chk_bvalid_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped before taken");
endmodule

/* scp_card_model.sv */
`timescale 1ns/10ps
module scp_card_model (
  // device drive side
  input wire logic c4Out,
  input wire logic c4Oe,
  input wire logic c8Out,
  input wire logic c8Oe,
  input wire logic extIoOut,
  input wire logic extIoOe,
  // card levels chosen by the bench: c4, c8, ext io
  input wire logic [2:0] cardLvl,
  // resolved pin levels
  output logic c4In,
  output logic c8In,
  output logic extIoIn
);
  // the card drives a contact only while the device has let go of it
  assign c4In = c4Oe ? c4Out : cardLvl[0];
  assign c8In = c8Oe ? c8Out : cardLvl[1];
  // the external chip has no reset or supply line here; those go over the serial bus
  assign extIoIn = extIoOe ? extIoOut : cardLvl[2];
endmodule

/* scp_pin_ctl_tb.sv */
`timescale 1ns/10ps
`include "scp_consts.svh"
module scp_pin_ctl_tb;
  import scp_pkg::*;
  logic ref_clk, resetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic [17:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  scp_resp_t bresp, rresp, rs;
  logic c4In, c4Out, c4Oe, c8In, c8Out, c8Oe, intCardClk, extIoIn, extIoOut, extIoOe, extCardClk;
  logic [2:0] cardLvl;
  logic [1:0] iS, eS, d, dat, pin;
  logic b;
  int miscompares, total_checks;

  scp_pin_ctl #(.ADDR_W(18), .CLK_HALF(2)) scp_pin_ctl_i (.ref_clk(ref_clk), .resetn(resetn),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid_unused_n(1'b0), .rvalid(rvalid),
    .rready(rready), .rdata(rdata), .rresp(rresp), .c4In(c4In), .c4Out(c4Out), .c4Oe(c4Oe), .c8In(c8In),
    .c8Out(c8Out), .c8Oe(c8Oe), .intCardClk(intCardClk), .extIoIn(extIoIn), .extIoOut(extIoOut),
    .extIoOe(extIoOe), .extCardClk(extCardClk));
  scp_card_model scp_card_model_i (.c4Out(c4Out), .c4Oe(c4Oe), .c8Out(c8Out), .c8Oe(c8Oe),
    .extIoOut(extIoOut), .extIoOe(extIoOe), .cardLvl(cardLvl), .c4In(c4In), .c8In(c8In), .extIoIn(extIoIn));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic axw(input logic [15:0] idx, input logic [7:0] v);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    awaddr <= {idx, 2'b00};
    wdata <= {24'h0, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // bready stays high between writes; only the watchdog ends a hung wait
    forever begin
      @(posedge ref_clk);
      if (bvalid === 1'b1) begin
        rs = bresp;
        break;
      end
      if (!aw && awready === 1'b1) begin
        aw = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w && wready === 1'b1) begin
        w = 1'b1;
        wvalid <= 1'b0;
      end
    end
  endtask

  task automatic axr(input logic [15:0] idx);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge ref_clk);
      if (rvalid === 1'b1) begin
        rd = rdata;
        rs = rresp;
        break;
      end
      if (arready === 1'b1) arvalid <= 1'b0;
    end
  endtask

  // set of levels a card clock should show over a window
  function automatic logic [1:0] expClk(input logic byp, input logic stop, input logic lvl);
    return (byp || stop) ? (lvl ? 2'b10 : 2'b01) : 2'b11;
  endfunction

  function automatic logic [31:0] expAux(input logic [1:0] dir, input logic [1:0] v, input logic [1:0] p);
    return {28'h0, (dir & p) | (~dir & v), 2'b00};
  endfunction

  task automatic watch();
    iS = 2'b00;
    eS = 2'b00;
    repeat (2) @(posedge ref_clk);
    repeat (12) begin
      @(posedge ref_clk);
      iS[intCardClk] = 1'b1;
      eS[extCardClk] = 1'b1;
    end
  endtask

  initial begin
    #(40000 * 5);
    miscompares++;
    wrap_up();
  end

  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    cardLvl = 3'h0;
    resetn = 1'b0;
    void'($urandom(32'h858a));
    repeat (20) @(posedge ref_clk);
    resetn <= 1'b1;
    axr(`SCP_IDX_EXT_CTL);
    chk(rd, 32'h0);
    chk(32'(rs), 32'(`SCP_RESP_OKAY));
    axr(16'hFE0D);
    chk(rd, 32'h0);
    chk(32'(rs), 32'(`SCP_RESP_DECERR));
    axw(16'hFE0D, 8'hFF);
    chk(32'(rs), 32'(`SCP_RESP_DECERR));
    axw(`SCP_IDX_EXT_CTL, 8'hFF);
    axr(`SCP_IDX_EXT_CTL);
    chk(rd, 32'h33);
    $display("registers done");
    for (int k = 0; k < 8; k++) begin
      axw(`SCP_IDX_MODE, {7'h0, k[2]});
      axw(`SCP_IDX_INT_CTL, {6'h0, k[0], k[1]});
      axw(`SCP_IDX_EXT_CTL, {6'h0, k[0], k[1]});
      watch();
      chk(32'(iS), 32'(expClk(k[2], k[1], k[0])));
      chk(32'(eS), 32'(expClk(k[2], k[1], k[0])));
    end
    $display("card clocks done");
    for (int k = 0; k < 8; k++) begin
      d = 2'($urandom);
      dat = 2'($urandom);
      pin = 2'($urandom);
      cardLvl[1:0] <= {pin[1], pin[0]};
      axw(`SCP_IDX_AUX_DIR, {4'h0, d, 2'b00});
      axw(`SCP_IDX_INT_CTL, {4'h0, dat, 2'b00});
      repeat (4) @(posedge ref_clk);
      axr(`SCP_IDX_INT_CTL);
      chk(rd, expAux(d, dat, pin));
      chk(32'({c8Oe, c4Oe}), 32'({~d}));
      chk(32'({c8Out, c4Out} & {~d}), 32'(dat & {~d}));
      axw(`SCP_IDX_AUX_DIR, 8'h00);
      chk(32'({c8Out, c4Out}), 32'(dat));
    end
    $display("aux contacts done");
    axw(`SCP_IDX_MODE, 8'h00);
    axw(`SCP_IDX_EXT_CTL, 8'h20);
    chk(32'(extIoOe), 32'h0);
    axw(`SCP_IDX_MODE, 8'h01);
    chk(32'({extIoOe, extIoOut}), 32'h3);
    axw(`SCP_IDX_EXT_CTL, 8'h00);
    chk(32'({extIoOe, extIoOut}), 32'h2);
    for (int k = 0; k < 4; k++) begin
      b = 1'($urandom);
      cardLvl[2] <= b;
      axw(`SCP_IDX_EXT_CTL, 8'h10);
      repeat (4) @(posedge ref_clk);
      axr(`SCP_IDX_EXT_CTL);
      chk(rd, {26'h0, b, 5'h10});
    end
    // io is turned round to input before the clock is started again
    axw(`SCP_IDX_MODE, 8'h04);
    for (int k = 0; k < 6; k++) begin
      b = 1'($urandom);
      cardLvl[2] <= b;
      repeat (16) @(posedge ref_clk);
      axr(`SCP_IDX_EXT_CTL);
      chk(32'(rd[5]), 32'(b));
      chk(32'(extIoOe), 32'h0);
    end
    $display("external io done");
    wrap_up();
  end
endmodule
